// File: lpc_lock_pkg.sv
// Purpose: Shared constants and types for the LPC access lock bank.
// Assumes: One clock domain; the register index times four is the APB byte address.
// Notes: Slot numbers equal lock bit positions of access_lock_config_two.
package lpc_lock_pkg;

	// Register indices; byte address is four times the index.
	localparam logic [3:0] IDX_STATUS = 4'h0;
	localparam logic [3:0] IDX_MODE = 4'h1;
	localparam logic [3:0] IDX_MASK = 4'h2;
	localparam logic [3:0] IDX_ACTIVE = 4'h3;
	localparam logic [3:0] IDX_LOCK = 4'h6;

	// Lock register layout and reset.
	localparam logic [7:0] LOCK_RESET = 8'h00;
	localparam logic [7:0] LOCK_WRITE_MASK = 8'hef;
	localparam int unsigned BIT_WAKE = 7;
	localparam int unsigned BIT_RTC = 6;
	localparam int unsigned BIT_XBUS = 5;
	localparam int unsigned BIT_CS3 = 3;

	// Status register layout: per-slot violation bits plus the summary flag.
	localparam int unsigned STATUS_W = 9;
	localparam int unsigned BIT_VIOL_FLAG = 8;
	localparam logic [8:0] STATUS_RESET = 9'h000;
	localparam logic [8:0] MASK_RESET = 9'h000;

	// Mode register layout.
	localparam int unsigned MODE_LSB = 0;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// Answer given to the LPC host on a locked access.
	typedef enum logic [1:0] {
		RESP_NO_SYNC,
		RESP_ERROR_SYNC,
		RESP_ONES,
		RESP_RESERVED
	} resp_mode_t;

	// Module addressed by a decoded host or management cycle.
	typedef enum logic [3:0] {
		TGT_NONE,
		TGT_CS0,
		TGT_CS1,
		TGT_CS2,
		TGT_CS3,
		TGT_XBUS,
		TGT_RTC,
		TGT_WAKE,
		TGT_ACPI
	} target_t;

	typedef struct packed {
		logic valid;
		logic write;
		target_t target;
	} lpc_cycle_t;

	typedef struct packed {
		logic grant;
		logic deny;
		resp_mode_t resp;
		logic [2:0] slot;
	} lpc_verdict_t;

endpackage

// File: lpc_lock_check.sv
// Purpose: Decides, per decoded LPC cycle, whether the host may reach the target.
// Assumes: The decoder presents one-cycle requests on the same clock.
// Notes: The verdict appears one edge after the request.
module lpc_lock_check (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Current lock state and response mode.
	input wire logic [7:0] lockBits,
	input wire lpc_lock_pkg::resp_mode_t respMode,
	// Decoded host cycle and verdict.
	input wire lpc_lock_pkg::lpc_cycle_t lpcCycle,
	output lpc_lock_pkg::lpc_verdict_t verdict
);

	logic guarded;
	logic [2:0] slot;
	lpc_lock_pkg::lpc_verdict_t verdict_reg;
	lpc_lock_pkg::lpc_verdict_t verdict_next;

	// The power-management registers and unknown targets are never guarded.
	always_comb begin
		guarded = 1'b1;
		slot = 3'h0;
		case (lpcCycle.target)
			lpc_lock_pkg::TGT_CS0: slot = 3'h0;
			lpc_lock_pkg::TGT_CS1: slot = 3'h1;
			lpc_lock_pkg::TGT_CS2: slot = 3'h2;
			lpc_lock_pkg::TGT_CS3: slot = 3'(lpc_lock_pkg::BIT_CS3);
			lpc_lock_pkg::TGT_XBUS: slot = 3'(lpc_lock_pkg::BIT_XBUS);
			lpc_lock_pkg::TGT_RTC: slot = 3'(lpc_lock_pkg::BIT_RTC);
			lpc_lock_pkg::TGT_WAKE: slot = 3'(lpc_lock_pkg::BIT_WAKE);
			lpc_lock_pkg::TGT_ACPI: guarded = 1'b0;
			default: guarded = 1'b0;
		endcase
	end

	// Lock bits are sampled live at every decode.
	always_comb begin
		verdict_next.slot = slot;
		verdict_next.resp = respMode;
		verdict_next.deny = lpcCycle.valid & guarded & lockBits[slot];
		verdict_next.grant = lpcCycle.valid & ~(guarded & lockBits[slot]);
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			verdict_reg <= '0;
		end else begin
			verdict_reg <= verdict_next;
		end
	end

	assign verdict = verdict_reg;

endmodule

// File: module_activation.sv
// Purpose: Computes the effective activation of each lockable module.
// Assumes: Activation bits and the global enable come from same-clock logic.
// Notes: A lock forces activation so the management bus can always reach it.
module module_activation (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Inputs.
	input wire logic [7:0] lockBits,
	input wire logic [7:0] activateBits,
	input wire logic globalEnable,
	// Effective activation.
	output logic [7:0] moduleActive
);

	logic [7:0] active_reg;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : gen_slot
			always_ff @(posedge clk_sys or negedge rst_b) begin
				if (!rst_b) begin
					active_reg[i] <= 1'b0;
				end else begin
					active_reg[i] <= lockBits[i] | (activateBits[i] & globalEnable);
				end
			end
		end
	endgenerate

	assign moduleActive = active_reg;

endmodule

// File: lpc_access_lock_bank_two.sv
// Purpose: Second access lock register bank with APB access, verdicts and interrupt.
// Assumes: APB master on clk_sys; LPC and management decoders on clk_sys.
// Notes: Every APB access takes one access cycle; unmapped words answer pslverr.
//
// Contract
// - Reset clears lock register to zero.
// - Bit 7 locks wake controller from host.
// - Locked access: mode-selected answer, set flag.
// - Power-management registers stay reachable when locked.
// - Lock forces module active over enables.
// - Bit 6 locks real-time clock likewise.
// - Bit 5 locks expansion-bus module likewise.
// - Zero means open, one means locked.
// - Bits 3..0 lock chip-select devices likewise.
//
// Design decision made here: register access over APB.
module lpc_access_lock_bank_two (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Decoded LPC host cycles.
	input wire lpc_lock_pkg::lpc_cycle_t lpcCycle,
	output lpc_lock_pkg::lpc_verdict_t lpcVerdict,
	// Decoded management bus cycles.
	input wire lpc_lock_pkg::lpc_cycle_t mgmtCycle,
	output logic mgmtGrant,
	// Module activation.
	input wire logic [7:0] activateBits,
	input wire logic globalEnable,
	output logic [7:0] moduleActive,
	// Interrupt.
	output logic irq
);

	// Registers.
	logic [7:0] lock_reg;
	logic [7:0] lock_next;
	lpc_lock_pkg::resp_mode_t mode_reg;
	lpc_lock_pkg::resp_mode_t mode_next;
	logic [lpc_lock_pkg::STATUS_W-1:0] status_reg;
	logic [lpc_lock_pkg::STATUS_W-1:0] status_next;
	logic [lpc_lock_pkg::STATUS_W-1:0] mask_reg;
	logic [lpc_lock_pkg::STATUS_W-1:0] mask_next;
	logic [3:0] lastSlot_reg;
	logic [3:0] lastSlot_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pslverr_reg;
	logic pslverr_next;
	logic irq_reg;
	logic mgmtGrant_reg;

	// Bus decode.
	logic setupPhase;
	logic writeTaken;
	logic [3:0] wordIdx;
	logic mapped;
	logic [lpc_lock_pkg::STATUS_W-1:0] statusSet;
	logic [lpc_lock_pkg::STATUS_W-1:0] statusClr;

	// Block outputs.
	lpc_lock_pkg::lpc_verdict_t verdict;
	logic [7:0] activeNow;

	assign setupPhase = psel & ~penable;
	assign writeTaken = psel & penable & pready_reg & pwrite;
	assign wordIdx = paddr[5:2];

	always_comb begin
		mapped = 1'b0;
		if (paddr[7:6] == 2'h0) begin
			case (wordIdx)
				lpc_lock_pkg::IDX_STATUS: mapped = 1'b1;
				lpc_lock_pkg::IDX_MODE: mapped = 1'b1;
				lpc_lock_pkg::IDX_MASK: mapped = 1'b1;
				lpc_lock_pkg::IDX_ACTIVE: mapped = 1'b1;
				lpc_lock_pkg::IDX_LOCK: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	end

	// Verdict engine.
	lpc_lock_check u_check (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.lockBits(lock_reg),
		.respMode(mode_reg),
		.lpcCycle(lpcCycle),
		.verdict(verdict)
	);

	// Activation override.
	module_activation u_active (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.lockBits(lock_reg),
		.activateBits(activateBits),
		.globalEnable(globalEnable),
		.moduleActive(activeNow)
	);

	// Lock register; the reserved bit cannot be set.
	always_comb begin
		lock_next = lock_reg;
		if (writeTaken && mapped && wordIdx == lpc_lock_pkg::IDX_LOCK) begin
			lock_next = pwdata[7:0] & lpc_lock_pkg::LOCK_WRITE_MASK;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lock_reg <= lpc_lock_pkg::LOCK_RESET;
		end else begin
			lock_reg <= lock_next;
		end
	end

	// Violation response mode.
	always_comb begin
		mode_next = mode_reg;
		if (writeTaken && mapped && wordIdx == lpc_lock_pkg::IDX_MODE) begin
			mode_next = lpc_lock_pkg::resp_mode_t'(pwdata[lpc_lock_pkg::MODE_LSB +: 2]);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_reg <= lpc_lock_pkg::resp_mode_t'(lpc_lock_pkg::MODE_RESET);
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Interrupt mask.
	always_comb begin
		mask_next = mask_reg;
		if (writeTaken && mapped && wordIdx == lpc_lock_pkg::IDX_MASK) begin
			mask_next = pwdata[lpc_lock_pkg::STATUS_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mask_reg <= lpc_lock_pkg::MASK_RESET;
		end else begin
			mask_reg <= mask_next;
		end
	end

	// Sticky violation status. A new violation in the cycle of a clear
	// survives, so software never misses an event by clearing late.
	always_comb begin
		statusSet = '0;
		if (verdict.deny) begin
			statusSet[verdict.slot] = 1'b1;
			statusSet[lpc_lock_pkg::BIT_VIOL_FLAG] = 1'b1;
		end
		statusClr = '0;
		if (writeTaken && mapped && wordIdx == lpc_lock_pkg::IDX_STATUS) begin
			statusClr = pwdata[lpc_lock_pkg::STATUS_W-1:0];
		end
		status_next = (status_reg & ~statusClr) | statusSet;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			status_reg <= lpc_lock_pkg::STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// Last violating slot, kept for diagnosis; bit 3 marks it valid.
	always_comb begin
		lastSlot_next = lastSlot_reg;
		if (verdict.deny) begin
			lastSlot_next = {1'b1, verdict.slot};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lastSlot_reg <= 4'h0;
		end else begin
			lastSlot_reg <= lastSlot_next;
		end
	end

	// Interrupt follows the next status so it rises with the status bit.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(status_next & mask_next);
		end
	end

	// The management bus is refused only for TGT_NONE, locked or not.
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mgmtGrant_reg <= 1'b0;
		end else begin
			mgmtGrant_reg <= mgmtCycle.valid & (mgmtCycle.target != lpc_lock_pkg::TGT_NONE);
		end
	end

	// Read data is captured in the setup cycle so it comes from a flop.
	always_comb begin
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		if (setupPhase) begin
			prdata_next = 32'h0000_0000;
			pslverr_next = ~mapped;
			if (!pwrite && mapped) begin
				case (wordIdx)
					lpc_lock_pkg::IDX_STATUS: prdata_next[lpc_lock_pkg::STATUS_W-1:0] = status_reg;
					lpc_lock_pkg::IDX_MODE: prdata_next[lpc_lock_pkg::MODE_LSB +: 2] = mode_reg;
					lpc_lock_pkg::IDX_MASK: prdata_next[lpc_lock_pkg::STATUS_W-1:0] = mask_reg;
					lpc_lock_pkg::IDX_ACTIVE: prdata_next[11:0] = {lastSlot_reg, activeNow};
					lpc_lock_pkg::IDX_LOCK: prdata_next[7:0] = lock_reg;
					default: prdata_next = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
			pready_reg <= 1'b0;
		end else begin
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
			pready_reg <= setupPhase;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign lpcVerdict = verdict;
	assign mgmtGrant = mgmtGrant_reg;
	assign moduleActive = activeNow;
	assign irq = irq_reg;

endmodule

// File: host_side_model.sv
// Purpose: Far-side model that issues decoded host and management cycles.
// Assumes: Requests come from the bench one cycle at a time.
// Notes: Target reads as none outside a cycle, so a stale code never looks live.
module host_side_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Request from the bench.
	input wire logic req,
	input wire logic reqMgmt,
	input wire logic [3:0] reqTarget,
	// Decoded cycles toward the bank.
	output lpc_lock_pkg::lpc_cycle_t lpcCycle,
	output lpc_lock_pkg::lpc_cycle_t mgmtCycle
);
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			lpcCycle <= '0;
			mgmtCycle <= '0;
		end else begin
			lpcCycle <= '{req && !reqMgmt, 1'b0,
				lpc_lock_pkg::target_t'(req && !reqMgmt ? reqTarget : 4'h0)};
			mgmtCycle <= '{req && reqMgmt, 1'b0,
				lpc_lock_pkg::target_t'(req && reqMgmt ? reqTarget : 4'h0)};
		end
	end
endmodule

// File: lpc_lock_asserts.sv
// Purpose: Port-level checks of the lock bank.
// Assumes: One clock; asynchronous active-low reset.
// Notes: Lock state is hidden here, so grant and slot checks lean on target codes.
module lpc_lock_asserts (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_b,
	// Watched ports.
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire lpc_lock_pkg::lpc_cycle_t lpcCycle,
	input wire lpc_lock_pkg::lpc_verdict_t lpcVerdict,
	input wire lpc_lock_pkg::lpc_cycle_t mgmtCycle,
	input wire logic mgmtGrant,
	input wire logic [7:0] activateBits,
	input wire logic globalEnable,
	input wire logic [7:0] moduleActive
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	a_apb_ready: assert property (psel && !penable |=> pready) else $error("no pready");
	a_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
	a_verdict_due: assert property (lpcCycle.valid |=> lpcVerdict.grant != lpcVerdict.deny)
		else $error("no verdict");
	a_verdict_idle: assert property (!lpcCycle.valid |=> !lpcVerdict.grant && !lpcVerdict.deny)
		else $error("stray verdict");
	a_acpi_open: assert property (lpcCycle.valid && lpcCycle.target == lpc_lock_pkg::TGT_ACPI
		|=> lpcVerdict.grant) else $error("power regs blocked");
	a_wake_slot: assert property (lpcVerdict.deny && $past(lpcCycle.target) == lpc_lock_pkg::TGT_WAKE
		|-> lpcVerdict.slot == 3'h7) else $error("wake slot wrong");
	a_rtc_slot: assert property (lpcVerdict.deny && $past(lpcCycle.target) == lpc_lock_pkg::TGT_RTC
		|-> lpcVerdict.slot == 3'h6) else $error("rtc slot wrong");
	a_mgmt_grant: assert property (mgmtCycle.valid && mgmtCycle.target != lpc_lock_pkg::TGT_NONE
		|=> mgmtGrant) else $error("mgmt refused");
	a_force_active: assert property (1'b1 |=> (($past(activateBits) & {8{$past(globalEnable)}})
		& ~moduleActive) == 8'h00) else $error("enabled module inactive");
	c_deny: cover property (lpcVerdict.deny);
	c_mgmt: cover property (mgmtGrant);
	c_err: cover property (pslverr);
endmodule
bind lpc_access_lock_bank_two lpc_lock_asserts portCheck (.clk_sys, .rst_b, .psel, .penable,
	.pready, .pslverr, .lpcCycle, .lpcVerdict, .mgmtCycle, .mgmtGrant, .activateBits,
	.globalEnable, .moduleActive);

// File: tb.sv
// Purpose: Self-checking bench for the lock bank.
// Assumes: Zero-wait APB slave; verdict one edge after a host cycle.
// Notes: Random locks, modes and targets come from a fixed seed.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic req = 1'b0;
	logic reqMgmt = 1'b0;
	logic [3:0] reqTgt = 4'h0;
	logic [7:0] activateBits = 8'h00;
	logic globalEnable = 1'b0;
	logic [31:0] prdata, rd, statExp;
	logic pready, pslverr, mgmtGrant, irq, err;
	logic [7:0] moduleActive, lockExp;
	logic [1:0] mode;
	logic [7:0] map [4] = '{8'h00, 8'h04, 8'h08, 8'h18};
	lpc_lock_pkg::lpc_cycle_t lpcCycle, mgmtCycle;
	lpc_lock_pkg::lpc_verdict_t lpcVerdict;
	int err_total = 0;
	int n_compared = 0;
	int cycles = 0;
	always #2 clk_sys = ~clk_sys;
	lpc_access_lock_bank_two DUT (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .lpcCycle, .lpcVerdict, .mgmtCycle, .mgmtGrant,
		.activateBits, .globalEnable, .moduleActive, .irq);
	host_side_model P (.clk_sys, .rst_b, .req, .reqMgmt, .reqTarget(reqTgt), .lpcCycle,
		.mgmtCycle);
	// Slot 8 stands for a target that no lock bit guards.
	function automatic logic [3:0] slot_of(input logic [3:0] t);
		return (t == 4'h0 || t > 4'h7) ? 4'h8 : (t < 4'h5 ? t - 4'h1 : t);
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wrap_up();
		if (err_total == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic host(input logic m, input logic [3:0] t);
		logic [3:0] s;
		logic lk;
		logic [6:0] exp;
		s = slot_of(t);
		lk = !m && s < 4'h8 && lockExp[s[2:0]];
		exp = {~lk, lk, lk ? {mode, s[2:0]} : 5'h0};
		req <= 1'b1;
		reqMgmt <= m;
		reqTgt <= t;
		@(posedge clk_sys);
		req <= 1'b0;
		@(posedge clk_sys);
		#1;
		if (m)
			chk("mgmtGrant", {31'h0, t != 4'h0}, {31'h0, mgmtGrant});
		else
			chk("verdict", exp, lk ? lpcVerdict : {lpcVerdict[6:5], 5'h0});
		if (lk)
			statExp = statExp | (32'h1 << s[2:0]) | 32'h100;
		chk("active", lockExp | (activateBits & {8{globalEnable}}), moduleActive);
		@(posedge clk_sys);
	endtask
	// A hang in any wait ends here rather than stalling the run.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			wrap_up();
		end
	end
	initial begin
		mode = 2'h0;
		statExp = 32'h0;
		lockExp = 8'h00;
		void'($urandom(20728));
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		foreach (map[i]) begin
			apb(1'b0, map[i], 32'h0);
			chk("reset word", 32'h0, rd);
		end
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, 8'h18, 32'hff);
		apb(1'b0, 8'h18, 32'h0);
		lockExp = 8'hef;
		chk("lock word", 32'hef, rd);
		apb(1'b1, 8'h08, 32'h100);
		host(1'b0, 4'h8);
		host(1'b0, 4'h7);
		host(1'b1, 4'h7);
		repeat (40) begin
			mode = 2'($urandom);
			lockExp = 8'($urandom) & 8'hef;
			activateBits <= 8'($urandom);
			globalEnable <= 1'($urandom);
			apb(1'b1, 8'h04, {30'h0, mode});
			apb(1'b1, 8'h18, {24'h0, lockExp});
			host(1'($urandom), 4'($urandom % 9));
		end
		apb(1'b0, 8'h0c, 32'h0);
		chk("active word", {24'h0, lockExp | (activateBits & {8{globalEnable}})}, {24'h0, rd[7:0]});
		apb(1'b0, 8'h00, 32'h0);
		chk("status", statExp, rd);
		chk("irq", {31'h0, statExp[8]}, {31'h0, irq});
		apb(1'b1, 8'h08, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, 8'h00, statExp);
		apb(1'b0, 8'h00, 32'h0);
		chk("status cleared", 32'h0, rd);
		wrap_up();
	end
endmodule
